// ---- include/printer_panel_map.svh ----
// offsets, fields, reset values and timing counts of the printer panel block
`ifndef PRINTER_PANEL_MAP_SVH
`define PRINTER_PANEL_MAP_SVH
`define CLK_HZ 50000000
`define EARLY_STEP_LIMIT 8'd28
`define RENEW_STEPS 8'd18
`define EARLY_RUN_MS 480
`define LATE_RUN_MS 1200
`define EARLY_RUN_CYCLES ((`CLK_HZ / 1000) * `EARLY_RUN_MS)
`define LATE_RUN_CYCLES ((`CLK_HZ / 1000) * `LATE_RUN_MS)
`define TEST_CHAR_CYCLES 50000
`define OFF_CTRL 4'h0
`define OFF_STAT 4'h4
`define OFF_IRQ_STAT 4'h8
`define OFF_IRQ_MASK 4'hc
`define CTRL_LATE 0
`define CTRL_RESET 32'h0000_0000
`define EV_JAM 0
`define EV_OVERVOLT 1
`define EV_SEQ_DONE 2
`define EV_WIDTH 3
`endif

// ---- include/printer_panel_pkg.sv ----
// types of the printer panel block
package printer_panel_pkg;
   typedef enum logic [1:0] {
      seq_idle = 2'b00,
      seq_run = 2'b01,
      seq_done = 2'b11
   } seq_state_type;
endpackage

// ---- design/printer_alarm_panel_control.sv ----
// printer alarm, lamp and high-voltage control with avalon register slave
`timescale 1ns/1ps
`include "printer_panel_map.svh"
//
// Notes on behaviour
// - early units: jam alarm if loop not renewed within 28 to 29 steps.
// - loop renewal after 18 steps clears the step count.
// - early units: jam alarm if pre-feed motor runs over 480 ms.
// - late units: alarm on paper-out switch or motor run over 1.2 s.
// - any alarm darkens ready lamp, lights jam lamp, inhibits printing.
// - jam button after fault cleared resets alarm and jam lamp.
// - active lamp released: paper, interlocks, motors and high voltage all on.
// - active lamp held: lights when all interlocks closed.
// - overvoltage turns off high voltage and ready lamp.
// - ready button resets overvoltage latch; lamp lights while held.
// - break held turns off reverse channel and lights break lamp.
// - transmit start runs calling generator; lamp lit until sequence ends.
// - paper alarm lamp on low supply; late units send test characters.
// - dataset bypass switch allows printing whatever the data set says.
// - open cover interlock, or open door interlock without override, turns off high voltage.
// - override switch bypasses the door interlocks.
module printer_alarm_panel_control #(
   parameter int unsigned EARLY_RUN_CYCLES = `EARLY_RUN_CYCLES,
   parameter int unsigned LATE_RUN_CYCLES = `LATE_RUN_CYCLES,
   parameter int unsigned TEST_CHAR_CYCLES = `TEST_CHAR_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // avalon-mm slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic avs_response_err,
   output logic irq,
   // paper transport
   input wire logic line_feed_step,
   input wire logic prefeed_motor_run,
   input wire logic paper_out_switch,
   input wire logic paper_low,
   input wire logic paper_present,
   // interlocks and supply
   input wire logic cover_interlock_closed,
   input wire logic door_interlock_closed,
   input wire logic override_switch,
   input wire logic overvoltage,
   input wire logic motors_on,
   input wire logic dataset_ready,
   input wire logic dataset_bypass_switch,
   // operator buttons and calling sequence done
   input wire logic jam_button,
   input wire logic active_button,
   input wire logic ready_button,
   input wire logic break_button,
   input wire logic transmit_start_button,
   input wire logic paper_alarm_button,
   input wire logic calling_seq_done,
   // lamps and controls
   output logic high_voltage_enable,
   output logic printer_enable,
   output logic ready_lamp,
   output logic active_lamp,
   output logic jam_lamp,
   output logic paper_alarm_lamp,
   output logic break_lamp,
   output logic reverse_channel_enable,
   output logic transmit_start_lamp,
   output logic calling_seq_start,
   output logic test_char_strobe
);
   ////////////////////////////////////////////////////////////////////////////////
   // control register and bus decode
   logic [31:0] ctrl_q;
   logic [`EV_WIDTH-1:0] irq_stat_q;
   logic [`EV_WIDTH-1:0] irq_mask_q;
   logic [31:0] readdata_q;
   logic rd_ack_q;
   wire late_mode = ctrl_q[`CTRL_LATE];
   wire sel_ctrl = (avs_address == `OFF_CTRL);
   wire sel_stat = (avs_address == `OFF_STAT);
   wire sel_istat = (avs_address == `OFF_IRQ_STAT);
   wire sel_imask = (avs_address == `OFF_IRQ_MASK);
   wire sel_any = sel_ctrl | sel_stat | sel_istat | sel_imask;
   wire wr_ctrl = avs_write && sel_ctrl && avs_byteenable[0];
   wire wr_istat = avs_write && sel_istat && avs_byteenable[0];
   wire wr_imask = avs_write && sel_imask && avs_byteenable[0];
   // reads take one wait cycle, writes none
   assign avs_waitrequest = avs_read && !rd_ack_q;
   assign avs_readdata = readdata_q;
   assign avs_response_err = (avs_read || avs_write) && !sel_any;
   ////////////////////////////////////////////////////////////////////////////////
   // jam supervision
   logic [7:0] step_cnt_q;
   logic [31:0] run_cnt_q;
   logic step_q;
   logic jam_q;
   wire step_rise = line_feed_step && !step_q;
   wire renew = prefeed_motor_run && (step_cnt_q >= `RENEW_STEPS);
   wire early_step_fault = !late_mode && (step_cnt_q > `EARLY_STEP_LIMIT);
   wire early_run_fault = !late_mode && (run_cnt_q > EARLY_RUN_CYCLES);
   wire late_fault = late_mode && (paper_out_switch || (run_cnt_q > LATE_RUN_CYCLES));
   wire fault_now = early_step_fault | early_run_fault | late_fault;
   wire jam_clear = jam_button && !fault_now;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         step_q <= 1'b0;
      end else begin
         step_q <= line_feed_step;
      end
   end
   // step count cleared by renewal, run count cleared on motor stop
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         step_cnt_q <= 8'h00;
      end else if (renew) begin
         step_cnt_q <= 8'h00;
      end else if (step_rise && step_cnt_q != 8'hff) begin
         step_cnt_q <= step_cnt_q + 8'h01;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         run_cnt_q <= 32'h0000_0000;
      end else if (!prefeed_motor_run) begin
         run_cnt_q <= 32'h0000_0000;
      end else if (run_cnt_q != 32'hffff_ffff) begin
         run_cnt_q <= run_cnt_q + 32'h0000_0001;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         jam_q <= 1'b0;
      end else if (fault_now) begin
         jam_q <= 1'b1;
      end else if (jam_clear) begin
         jam_q <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // interlocks, high voltage and lamps
   logic ov_q;
   wire doors_ok = door_interlock_closed || override_switch;
   wire interlocks_ok = cover_interlock_closed && doors_ok;
   wire dataset_ok = dataset_ready || dataset_bypass_switch;
   wire print_cond = paper_present && interlocks_ok && !jam_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ov_q <= 1'b0;
      end else if (overvoltage) begin
         ov_q <= 1'b1;
      end else if (ready_button) begin
         ov_q <= 1'b0;
      end
   end
   logic hv_q;
   logic ready_q;
   logic active_q;
   logic jam_lamp_q;
   logic printer_en_q;
   logic paper_lamp_q;
   logic break_lamp_q;
   logic rev_q;
   wire hv_d = interlocks_ok && !ov_q && !overvoltage && !jam_q && dataset_ok;
   wire ready_d = ready_button || (print_cond && !ov_q);
   wire active_d = active_button ? interlocks_ok
                                 : (paper_present && interlocks_ok && motors_on && hv_q);
   wire printer_en_d = print_cond && dataset_ok && hv_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hv_q <= 1'b0;
         ready_q <= 1'b0;
         active_q <= 1'b0;
         jam_lamp_q <= 1'b0;
         printer_en_q <= 1'b0;
         paper_lamp_q <= 1'b0;
         break_lamp_q <= 1'b0;
         rev_q <= 1'b0;
      end else begin
         hv_q <= hv_d;
         ready_q <= ready_d;
         active_q <= active_d;
         jam_lamp_q <= jam_q;
         printer_en_q <= printer_en_d;
         paper_lamp_q <= paper_low || paper_alarm_button;
         break_lamp_q <= break_button;
         rev_q <= !break_button;
      end
   end
   assign high_voltage_enable = hv_q;
   assign ready_lamp = ready_q;
   assign active_lamp = active_q;
   assign jam_lamp = jam_lamp_q;
   assign printer_enable = printer_en_q;
   assign paper_alarm_lamp = paper_lamp_q;
   assign break_lamp = break_lamp_q;
   assign reverse_channel_enable = rev_q;
   ////////////////////////////////////////////////////////////////////////////////
   // calling sequence and test characters
   printer_panel_pkg::seq_state_type seq_q;
   logic start_q;
   logic seq_start_q;
   logic [31:0] tc_cnt_q;
   logic tc_q;
   wire start_rise = transmit_start_button && !start_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         seq_q <= printer_panel_pkg::seq_idle;
         start_q <= 1'b0;
         seq_start_q <= 1'b0;
      end else begin
         start_q <= transmit_start_button;
         seq_start_q <= 1'b0;
         case (seq_q)
            printer_panel_pkg::seq_idle: begin
               if (start_rise) begin
                  seq_q <= printer_panel_pkg::seq_run;
                  seq_start_q <= 1'b1;
               end
            end
            printer_panel_pkg::seq_run: begin
               if (calling_seq_done) begin
                  seq_q <= printer_panel_pkg::seq_done;
               end
            end
            printer_panel_pkg::seq_done: begin
               seq_q <= printer_panel_pkg::seq_idle;
            end
            default: begin
               seq_q <= printer_panel_pkg::seq_idle;
            end
         endcase
      end
   end
   assign transmit_start_lamp = (seq_q == printer_panel_pkg::seq_run);
   assign calling_seq_start = seq_start_q;
   wire tc_wrap = (tc_cnt_q >= TEST_CHAR_CYCLES - 1);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tc_cnt_q <= 32'h0000_0000;
         tc_q <= 1'b0;
      end else if (!(late_mode && paper_alarm_button)) begin
         tc_cnt_q <= 32'h0000_0000;
         tc_q <= 1'b0;
      end else begin
         tc_cnt_q <= tc_wrap ? 32'h0000_0000 : tc_cnt_q + 32'h0000_0001;
         tc_q <= (tc_cnt_q == 32'h0000_0000);
      end
   end
   assign test_char_strobe = tc_q;
   ////////////////////////////////////////////////////////////////////////////////
   // interrupts and registers
   logic jam_prev_q;
   logic ov_prev_q;
   wire [`EV_WIDTH-1:0] ev = {seq_q == printer_panel_pkg::seq_done, ov_q && !ov_prev_q, jam_q && !jam_prev_q};
   wire [`EV_WIDTH-1:0] wclr = wr_istat ? avs_writedata[`EV_WIDTH-1:0] : {`EV_WIDTH{1'b0}};
   wire [31:0] stat_word = {24'h00_0000, paper_low, paper_out_switch, printer_en_q, hv_q, ov_q, jam_q,
                            seq_q == printer_panel_pkg::seq_run, interlocks_ok};
   wire [31:0] rd_mux = sel_ctrl ? ctrl_q :
                        sel_stat ? stat_word :
                        sel_istat ? {29'h0000_0000, irq_stat_q} :
                        sel_imask ? {29'h0000_0000, irq_mask_q} : 32'h0000_0000;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= `CTRL_RESET;
         irq_stat_q <= {`EV_WIDTH{1'b0}};
         irq_mask_q <= {`EV_WIDTH{1'b0}};
         jam_prev_q <= 1'b0;
         ov_prev_q <= 1'b0;
         readdata_q <= 32'h0000_0000;
         rd_ack_q <= 1'b0;
      end else begin
         jam_prev_q <= jam_q;
         ov_prev_q <= ov_q;
         irq_stat_q <= (irq_stat_q & ~wclr) | ev;
         if (wr_ctrl) begin
            ctrl_q <= {31'h0000_0000, avs_writedata[`CTRL_LATE]};
         end
         if (wr_imask) begin
            irq_mask_q <= avs_writedata[`EV_WIDTH-1:0];
         end
         rd_ack_q <= avs_read && !rd_ack_q;
         if (avs_read && !rd_ack_q) begin
            readdata_q <= rd_mux;
         end
      end
   end
   assign irq = |(irq_stat_q & irq_mask_q);
   ////////////////////////////////////////////////////////////////////////////////
   // assertions
   AST_EARLY_STEP: assert property (@(posedge clk) disable iff (rst)
      (!late_mode && step_cnt_q == 8'd29)
      |=> jam_q) else $error("no jam after 29 steps");
   AST_EARLY_ONLY: assert property (@(posedge clk) disable iff (rst)
      (late_mode && !late_fault && !jam_q)
      |=> !jam_q) else $error("step count alarm in late mode");
   AST_RENEW: assert property (@(posedge clk) disable iff (rst)
      renew
      |=> step_cnt_q == 8'h00) else $error("renewal did not clear steps");
   AST_EARLY_RUN: assert property (@(posedge clk) disable iff (rst)
      (!late_mode && run_cnt_q > EARLY_RUN_CYCLES)
      |=> jam_q) else $error("no jam on long run");
   AST_LATE_OUT: assert property (@(posedge clk) disable iff (rst)
      (late_mode && paper_out_switch)
      |=> jam_q) else $error("no alarm on paper out");
   AST_LATE_RUN: assert property (@(posedge clk) disable iff (rst)
      (late_mode && run_cnt_q > LATE_RUN_CYCLES)
      |=> jam_q) else $error("no alarm on long late run");
   AST_JAM_LAMPS: assert property (@(posedge clk) disable iff (rst)
      (jam_q && !ready_button)
      |=> (!ready_q && jam_lamp_q && !printer_en_q)) else $error("jam lamps wrong");
   AST_JAM_HV: assert property (@(posedge clk) disable iff (rst)
      jam_q
      |=> !hv_q) else $error("high voltage on during jam");
   AST_JAM_CLEAR: assert property (@(posedge clk) disable iff (rst)
      (jam_q && jam_clear)
      |=> !jam_q ##1 !jam_lamp_q) else $error("jam not cleared");
   AST_ACTIVE_REL: assert property (@(posedge clk) disable iff (rst)
      (!active_button && paper_present && interlocks_ok && motors_on && hv_q)
      |=> active_q) else $error("active lamp dark when ready");
   AST_ACTIVE_DARK: assert property (@(posedge clk) disable iff (rst)
      (!active_button && !(paper_present && motors_on && hv_q))
      |=> !active_q) else $error("active lamp lit when not ready");
   AST_ACTIVE_HELD: assert property (@(posedge clk) disable iff (rst)
      (active_button && interlocks_ok)
      |=> active_q) else $error("active lamp dark while held");
   AST_ACTIVE_OPEN: assert property (@(posedge clk) disable iff (rst)
      !interlocks_ok
      |=> !active_q) else $error("active lamp lit with interlock open");
   AST_OV_HV: assert property (@(posedge clk) disable iff (rst)
      overvoltage
      |=> (!hv_q && ov_q)) else $error("high voltage on in overvoltage");
   AST_OV_READY: assert property (@(posedge clk) disable iff (rst)
      (ov_q && !ready_button)
      |=> !ready_q) else $error("ready lamp lit in overvoltage");
   AST_READY_HELD: assert property (@(posedge clk) disable iff (rst)
      ready_button
      |=> ready_q) else $error("ready lamp dark while held");
   AST_OV_RESET: assert property (@(posedge clk) disable iff (rst)
      (ready_button && !overvoltage)
      |=> !ov_q) else $error("overvoltage latch not reset");
   AST_BREAK: assert property (@(posedge clk) disable iff (rst)
      break_button
      |=> (break_lamp_q && !rev_q)) else $error("break not honoured");
   AST_BREAK_REL: assert property (@(posedge clk) disable iff (rst)
      !break_button
      |=> (!break_lamp_q && rev_q)) else $error("break stuck after release");
   AST_SEQ_START: assert property (@(posedge clk) disable iff (rst)
      (seq_q == printer_panel_pkg::seq_idle && start_rise)
      |=> (seq_start_q && transmit_start_lamp)) else $error("calling sequence not started");
   AST_SEQ_END: assert property (@(posedge clk) disable iff (rst)
      (seq_q == printer_panel_pkg::seq_run && calling_seq_done)
      |=> !transmit_start_lamp) else $error("start lamp lit after sequence");
   AST_PAPER_LAMP: assert property (@(posedge clk) disable iff (rst)
      paper_low
      |=> paper_lamp_q) else $error("paper alarm lamp dark on low supply");
   AST_TEST_IDLE: assert property (@(posedge clk) disable iff (rst)
      !(late_mode && paper_alarm_button)
      |=> !tc_q) else $error("test character without button");
   AST_BYPASS: assert property (@(posedge clk) disable iff (rst)
      (dataset_bypass_switch && print_cond && hv_q)
      |=> printer_en_q) else $error("printing blocked in test position");
   AST_INTERLOCK: assert property (@(posedge clk) disable iff (rst)
      !cover_interlock_closed
      |=> !hv_q) else $error("high voltage with cover open");
   AST_DOOR: assert property (@(posedge clk) disable iff (rst)
      (!door_interlock_closed && !override_switch)
      |=> !hv_q) else $error("high voltage with door open");
   AST_OVERRIDE: assert property (@(posedge clk) disable iff (rst)
      (override_switch && cover_interlock_closed && !ov_q && !overvoltage && !jam_q && dataset_ok)
      |=> hv_q) else $error("override did not bypass doors");
   AST_RUN_CLR: assert property (@(posedge clk) disable iff (rst)
      !prefeed_motor_run
      |=> run_cnt_q == 32'h0000_0000) else $error("run count not cleared");
endmodule // printer_alarm_panel_control

// ---- verif/printer_panel_partner.sv ----
// paper transport and calling generator model facing the printer panel
`timescale 1ns/1ps
module printer_panel_partner (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // bench commands
   input wire logic step_req,
   input wire logic renew_en,
   input wire logic hold_run,
   // from the panel
   input wire logic calling_seq_start,
   // to the panel
   output logic line_feed_step,
   output logic prefeed_motor_run,
   output logic calling_seq_done
);
   logic [7:0] steps_q;
   logic [1:0] run_q;
   logic [2:0] seq_q;
   wire logic renew = renew_en && steps_q >= 8'd18 && run_q == 2'd0;
   assign prefeed_motor_run = (run_q != 2'd0) || hold_run;
   assign calling_seq_done = seq_q == 3'd1;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         line_feed_step <= 1'b0;
         steps_q <= 8'h00;
         run_q <= 2'h0;
         seq_q <= 3'h0;
      end else begin
         line_feed_step <= step_req;
         if (renew) begin
            steps_q <= 8'h00;
         end else if (step_req && !line_feed_step) begin
            steps_q <= steps_q + 8'h01;
         end
         run_q <= renew ? 2'h3 : run_q - 2'((run_q != 2'h0));
         seq_q <= calling_seq_start ? 3'h6 : seq_q - 3'((seq_q != 3'h0));
      end
   end
endmodule // printer_panel_partner

// ---- verif/printer_alarm_panel_control_tb.sv ----
// self-checking bench of the printer alarm panel control
`timescale 1ns/1ps
`include "printer_panel_map.svh"
module printer_alarm_panel_control_tb;
   logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, err;
   logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q, rnd = 32'hc196efd5;
   logic avs_waitrequest, avs_response_err, irq, line_feed_step, prefeed_motor_run, calling_seq_done;
   logic step_req = 0, renew_en = 0, hold_run = 0, paper_out_switch = 0, paper_low = 0, paper_present = 1;
   logic cover_interlock_closed = 1, door_interlock_closed = 1, override_switch = 0, overvoltage = 0;
   logic motors_on = 1, dataset_ready = 1, dataset_bypass_switch = 0, jam_button = 0, active_button = 0;
   logic ready_button = 0, paper_alarm_button = 0, break_button = 0, transmit_start_button = 0;
   logic high_voltage_enable, printer_enable, ready_lamp, active_lamp, jam_lamp, paper_alarm_lamp;
   logic break_lamp, reverse_channel_enable, transmit_start_lamp, calling_seq_start, test_char_strobe;
   int mismatches = 0, cmp_count = 0, strobes = 0, starts = 0, s0;
   always #10 clk = ~clk;
   always @(posedge clk) begin
      if (test_char_strobe === 1'b1) strobes <= strobes + 1;
      if (calling_seq_start === 1'b1) starts <= starts + 1;
   end
   printer_alarm_panel_control #(.EARLY_RUN_CYCLES(20), .LATE_RUN_CYCLES(40), .TEST_CHAR_CYCLES(4))
   printer_alarm_panel_control_inst (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response_err(avs_response_err),
      .irq(irq), .line_feed_step(line_feed_step), .prefeed_motor_run(prefeed_motor_run),
      .paper_out_switch(paper_out_switch), .paper_low(paper_low), .paper_present(paper_present),
      .cover_interlock_closed(cover_interlock_closed), .door_interlock_closed(door_interlock_closed),
      .override_switch(override_switch), .overvoltage(overvoltage), .motors_on(motors_on),
      .dataset_ready(dataset_ready), .dataset_bypass_switch(dataset_bypass_switch), .jam_button(jam_button),
      .active_button(active_button), .ready_button(ready_button), .break_button(break_button),
      .transmit_start_button(transmit_start_button), .paper_alarm_button(paper_alarm_button),
      .calling_seq_done(calling_seq_done), .high_voltage_enable(high_voltage_enable),
      .printer_enable(printer_enable), .ready_lamp(ready_lamp), .active_lamp(active_lamp), .jam_lamp(jam_lamp),
      .paper_alarm_lamp(paper_alarm_lamp), .break_lamp(break_lamp), .reverse_channel_enable(reverse_channel_enable),
      .transmit_start_lamp(transmit_start_lamp), .calling_seq_start(calling_seq_start),
      .test_char_strobe(test_char_strobe));
   printer_panel_partner printer_panel_partner_inst (.clk(clk), .rst(rst), .step_req(step_req),
      .renew_en(renew_en), .hold_run(hold_run), .calling_seq_start(calling_seq_start),
      .line_feed_step(line_feed_step), .prefeed_motor_run(prefeed_motor_run), .calling_seq_done(calling_seq_done));
   ////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic exp_active(input logic held, paper, il, motors);
      return held ? il : (paper && il && motors);
   endfunction
   function automatic logic exp_ready(input logic held, paper, il);
      return held || (paper && il);
   endfunction
   task automatic stop_test;
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge clk);
      end
      q = avs_readdata;
      err = avs_response_err;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask
   task automatic steps(input int n);
      repeat (n) begin
         step_req <= 1'b1;
         @(posedge clk);
         step_req <= 1'b0;
         rnd = lfsr(rnd);
         tick(2 + rnd[1:0]);
      end
      tick(3);
   endtask
   task automatic press_jam;
      jam_button <= 1'b1;
      tick(3);
      jam_button <= 1'b0;
      tick(3);
   endtask
   task automatic run_motor(input int n, input logic exp);
      hold_run <= 1'b1;
      tick(n);
      hold_run <= 1'b0;
      tick(3);
      chk(jam_lamp, exp);
      press_jam;
   endtask
   ////////////////////////////////////////
   initial begin
      tick(20000);
      mismatches++;
      stop_test;
   end
   initial begin
      tick(6);
      rst <= 1'b0;
      @(posedge clk);
      bus(0, `OFF_CTRL, 0);
      chk(q, `CTRL_RESET);
      bus(0, 4'h2, 0);
      chk({err, q[30:0]}, 32'h8000_0000);
      bus(1, `OFF_IRQ_MASK, 32'h1);
      steps(28);
      chk(jam_lamp, 0);
      steps(1);
      chk({jam_lamp, ready_lamp, printer_enable, irq}, 32'h9);
      press_jam;
      chk(jam_lamp, 1);
      renew_en <= 1'b1;
      tick(8);
      press_jam;
      chk({jam_lamp, ready_lamp}, 32'h1);
      bus(0, `OFF_IRQ_STAT, 0);
      chk(q[`EV_JAM], 1);
      bus(1, `OFF_IRQ_STAT, 32'h1);
      chk(irq, 0);
      steps(60);
      chk(jam_lamp, 0);
      run_motor(15, 0);
      run_motor(15, 0);
      run_motor(25, 1);
      bus(1, `OFF_CTRL, 32'h1);
      run_motor(30, 0);
      run_motor(45, 1);
      paper_out_switch <= 1'b1;
      tick(3);
      chk({jam_lamp, ready_lamp}, 32'h2);
      paper_out_switch <= 1'b0;
      press_jam;
      paper_low <= 1'b1;
      paper_alarm_button <= 1'b1;
      s0 = strobes;
      tick(20);
      chk((strobes - s0) inside {[4:6]}, 1);
      chk(paper_alarm_lamp, 1);
      paper_low <= 1'b0;
      paper_alarm_button <= 1'b0;
      overvoltage <= 1'b1;
      @(posedge clk);
      overvoltage <= 1'b0;
      tick(3);
      chk({high_voltage_enable, ready_lamp, irq}, 32'h1);
      bus(0, `OFF_IRQ_STAT, 0);
      chk(q[`EV_OVERVOLT], 1);
      ready_button <= 1'b1;
      tick(3);
      chk(ready_lamp, 1);
      ready_button <= 1'b0;
      tick(4);
      chk({ready_lamp, high_voltage_enable}, 32'h3);
      bus(0, `OFF_STAT, 0);
      chk(q, 32'h31);
      dataset_ready <= 1'b0;
      dataset_bypass_switch <= 1'b1;
      door_interlock_closed <= 1'b0;
      tick(4);
      chk({printer_enable, high_voltage_enable}, 32'h0);
      override_switch <= 1'b1;
      tick(4);
      chk({printer_enable, high_voltage_enable}, 32'h3);
      dataset_ready <= 1'b1;
      dataset_bypass_switch <= 1'b0;
      door_interlock_closed <= 1'b1;
      override_switch <= 1'b0;
      break_button <= 1'b1;
      tick(3);
      chk({break_lamp, reverse_channel_enable}, 32'h2);
      break_button <= 1'b0;
      s0 = starts;
      transmit_start_button <= 1'b1;
      tick(3);
      transmit_start_button <= 1'b0;
      chk({transmit_start_lamp, reverse_channel_enable}, 32'h3);
      tick(12);
      chk({transmit_start_lamp, 31'(starts - s0)}, 32'h1);
      bus(0, `OFF_IRQ_STAT, 0);
      chk(q[`EV_SEQ_DONE], 1);
      repeat (8) begin
         rnd = lfsr(rnd);
         active_button <= rnd[0];
         paper_present <= rnd[1];
         motors_on <= rnd[2];
         cover_interlock_closed <= rnd[3] | rnd[4];
         ready_button <= rnd[5];
         tick(4);
         chk(active_lamp, exp_active(rnd[0], rnd[1], rnd[3] | rnd[4], rnd[2]));
         chk(ready_lamp, exp_ready(rnd[5], rnd[1], rnd[3] | rnd[4]));
         chk(high_voltage_enable, rnd[3] | rnd[4]);
      end
      stop_test;
   end
endmodule // printer_alarm_panel_control_tb
